// ===== src/selfprog_pkg.sv
package selfprog_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  // programming time window, in microseconds
  localparam int unsigned PROG_MIN_US = 3700;
  localparam int unsigned PROG_MAX_US = 4500;
  // cycles per microsecond round down; aim at the least so the longest is never passed
  localparam int unsigned PROG_CYCLES = (PROG_MIN_US * (CLK_HZ / 1_000_000));
  localparam int unsigned ARM_WINDOW = 4;

  // register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] POINTER_ADDR = 8'h04;
  localparam logic [7:0] DATA_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0C;
  localparam logic [7:0] CONFIG_ADDR = 8'h10;
  localparam logic [7:0] LOCK_ADDR = 8'h14;
  localparam logic [7:0] VECTOR_ADDR = 8'h18;
  localparam logic [7:0] BUFREAD_ADDR = 8'h1C;

  // control register fields
  localparam int unsigned CTL_ENABLE = 0;
  localparam int unsigned CTL_ERASE = 1;
  localparam int unsigned CTL_WRITE = 2;
  localparam int unsigned CTL_LOCK = 3;
  localparam int unsigned CTL_REENABLE = 4;
  localparam int unsigned CTL_BUSY = 6;
  localparam int unsigned CTL_IRQ_EN = 7;
  localparam logic [5:0] CMD_MASK = 6'h1F;
  localparam logic [5:0] PAT_LOAD = 6'h01;
  localparam logic [5:0] PAT_ERASE = 6'h03;
  localparam logic [5:0] PAT_WRITE = 6'h05;
  localparam logic [5:0] PAT_LOCK = 6'h09;
  localparam logic [5:0] PAT_REENABLE = 6'h11;

  localparam logic [15:0] APP_RESET_VECTOR = 16'h0000;
  localparam logic [5:0] LOCK_RESET = 6'h3F;
  localparam int unsigned LOCK_BITS = 6;

  typedef enum logic [1:0] {
    OP_ERASE,
    OP_WRITE,
    OP_LOCK
  } flash_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY
  } seq_state_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_t;

  // flash array side: one operation request and the word stream for a page write
  typedef struct packed {
    logic start;
    flash_op_t op;
    logic [15:0] page_base;
    logic [15:0] word;
    logic [5:0] lock_clear_mask;
  } flash_cmd_t;

endpackage

// ===== src/flash_self_programming_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// [R1] boot fuse 1 gives reset vector 0x0000; 0 gives boot loader start address
// [R2] fuses are inputs only; nothing software does can alter them
// [R3] pointer splits into word-in-page low bits and page high bits
// [R4] target page latched at command start; later pointer writes have no effect
// [R5] lock programming ignores the pointer completely
// [R6] byte reads use pointer bit 0 to pick low or high byte
// [R7] pattern X0000011 then store within four cycles erases the pointer's page
// [R8] erase of the halting section halts the cpu; other section stays readable
// [R9] pattern 00000001 then store loads R1:R0 into buffer at word field
// [R10] buffer cleared after page write, on re-enable write and at reset
// [R11] software loads each buffer word once between clears
// [R12] an eeprom write during page loading discards the loaded buffer
// [R13] pattern X0000101 then store writes the buffer into the pointer's page
// [R14] page write to the halting section halts the cpu until done
// [R15] ready interrupt held while enabled and enable bit clear
// [R16] erase or write blocks the readable section and sets its busy flag
// [R17] re-enable write clears the busy flag after programming
// [R18] pattern X0001001 then store programs lock bits from R0 bits 5..0
// [R19] each lock bit whose R0 bit is zero becomes programmed
// [R20] lock programming halts nothing and blocks no section
// [R21] eeprom write busy refuses programming commands and fuse or lock reads; code refuses arming, buffer loads and lock reads; armed operations still start
// [R22] software checks eeprom busy before writing the control register
// [R23] armed bits self clear if no store within four cycles
// [R24] each operation lasts between 3.7ms and 4.5ms
// [R25] enable bit stays set from arming until the operation completes
module flash_self_programming_ctrl
  import selfprog_pkg::*;
#(
  parameter int unsigned WORD_BITS = 6,
  parameter int unsigned PROG_TIME = PROG_CYCLES,
  parameter logic [15:0] BOOT_START = 16'h1C00,
  parameter logic [15:0] HALT_SECTION_START = 16'h1C00
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire axil_req_t bus_req,
  output axil_rsp_t bus_rsp,
  input wire logic store_strobe,
  input wire logic boot_vector_select_fuse,
  input wire logic eeprom_write_busy,
  input wire logic eeprom_write_start,
  output logic [15:0] reset_vector,
  output logic cpu_halt,
  output logic section_busy_flag,
  output logic ready_irq,
  output flash_cmd_t flash_cmd
);

  localparam int unsigned WORDS = 1 << WORD_BITS;
  localparam int unsigned TW = $clog2(PROG_TIME + 1);

  initial begin
    if (WORD_BITS < 1 || WORD_BITS > 8 || PROG_TIME < 1) begin
      $error("flash_self_programming_ctrl: unsupported parameter values");
    end
  end

  typedef struct packed {
    axil_rsp_t rsp;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    seq_state_t state;
    logic [5:0] ctrl;
    logic irq_en;
    logic [2:0] arm_cnt;
    logic [15:0] pointer;
    logic [15:0] data_word;
    logic [WORDS-1:0][15:0] buffer;
    logic [WORDS-1:0] loaded;
    logic [5:0] lock_bits;
    logic [15:0] latch_page;
    flash_op_t op;
    logic [TW-1:0] timer;
    logic busy_flag;
    logic halt;
    logic irq;
    logic [15:0] vector;
    logic vec_done;
    logic [2:0] eep_sync;
    logic eep_busy;
    flash_cmd_t cmd;
  } state_t;

  state_t cur_reg;
  state_t cur_next;

  function automatic logic [15:0] page_of(input logic [15:0] ptr);
    page_of = ptr & ~16'((1 << (WORD_BITS + 1)) - 1); // see [R3]
  endfunction

  function automatic logic [WORD_BITS-1:0] word_of(input logic [15:0] ptr);
    word_of = ptr[WORD_BITS:1]; // see [R3]
  endfunction

  function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] a);
    logic [15:0] w;
    w = s.buffer[word_of(s.pointer)];
    read_mux = 32'h0000_0000;
    if (a == CTRL_ADDR) begin
      read_mux = {24'h00_0000, s.irq_en, s.busy_flag, 1'b0, s.ctrl[4:0]};
    end else if (a == POINTER_ADDR) begin
      read_mux = {16'h0000, s.pointer};
    end else if (a == DATA_ADDR) begin
      read_mux = {16'h0000, s.data_word};
    end else if (a == STATUS_ADDR) begin
      read_mux = {28'h000_0000, s.eep_busy, s.halt, s.busy_flag, s.state == ST_BUSY};
    end else if (a == LOCK_ADDR) begin
      if (!s.eep_busy) begin
        read_mux = {24'h00_0000, 2'b11, s.lock_bits}; // see [R21]
      end
    end else if (a == VECTOR_ADDR) begin
      read_mux = {16'h0000, s.vector};
    end else if (a == BUFREAD_ADDR) begin
      read_mux = {24'h00_0000, s.pointer[0] ? w[15:8] : w[7:0]}; // see [R6]
    end
  endfunction

  always_comb begin
    logic [5:0] pat;
    logic armed;
    logic wr_fire;
    cur_next = cur_reg;
    pat = 6'h00;
    armed = 1'b0;
    wr_fire = 1'b0;
    cur_next.cmd.start = 1'b0;

    cur_next.eep_sync = {cur_reg.eep_sync[1:0], eeprom_write_busy};
    if (cur_reg.eep_sync[2] == cur_reg.eep_sync[1]) begin
      cur_next.eep_busy = cur_reg.eep_sync[1];
    end

    // fuse sampled once after reset release; fuses are never written here
    if (!cur_reg.vec_done) begin
      cur_next.vector = boot_vector_select_fuse ? APP_RESET_VECTOR : BOOT_START; // see [R1] [R2]
      cur_next.vec_done = 1'b1;
    end

    // bus write channel
    if (bus_req.awvalid && !cur_reg.aw_got) begin
      cur_next.aw_got = 1'b1;
      cur_next.aw_addr = bus_req.awaddr[7:0];
    end
    if (bus_req.wvalid && !cur_reg.w_got) begin
      cur_next.w_got = 1'b1;
      cur_next.w_data = bus_req.wdata;
    end
    cur_next.rsp.awready = !cur_next.aw_got && !cur_reg.rsp.bvalid;
    cur_next.rsp.wready = !cur_next.w_got && !cur_reg.rsp.bvalid;
    if (cur_reg.rsp.bvalid && bus_req.bready) begin
      cur_next.rsp.bvalid = 1'b0;
    end

    // armed window counts down; bits self clear when it runs out
    if (cur_reg.arm_cnt != 3'd0) begin
      cur_next.arm_cnt = cur_reg.arm_cnt - 3'd1;
      // a store in the last armed cycle still wins over the self clear
      if (cur_reg.arm_cnt == 3'd1 && !store_strobe) begin
        cur_next.ctrl = 6'h00; // see [R23]
      end
    end

    if (cur_reg.aw_got && cur_reg.w_got && !cur_reg.rsp.bvalid) begin
      cur_next.aw_got = 1'b0;
      cur_next.w_got = 1'b0;
      cur_next.rsp.bvalid = 1'b1;
      cur_next.rsp.bresp = 2'b00;
      wr_fire = 1'b1;
      if (cur_reg.aw_addr == CTRL_ADDR) begin
        if (cur_reg.w_data[0]) begin
          cur_next.irq_en = cur_reg.w_data[CTL_IRQ_EN];
        end
        cur_next.irq_en = cur_reg.w_data[CTL_IRQ_EN];
        // a busy operation or a busy eeprom refuses new arming
        if (cur_reg.state == ST_IDLE && !cur_reg.eep_busy) begin // see [R21] [R22]
          pat = cur_reg.w_data[5:0] & CMD_MASK;
          if (pat == PAT_REENABLE) begin
            cur_next.busy_flag = 1'b0; // see [R17]
            cur_next.loaded = '0; // see [R10]
            cur_next.buffer = '0;
            cur_next.ctrl = 6'h00;
          end else if (pat == PAT_LOAD || pat == PAT_ERASE || pat == PAT_WRITE
                       || pat == PAT_LOCK) begin
            cur_next.ctrl = pat;
            cur_next.arm_cnt = 3'(ARM_WINDOW);
            armed = 1'b1;
          end
        end
      end else if (cur_reg.aw_addr == POINTER_ADDR) begin
        cur_next.pointer = cur_reg.w_data[15:0];
      end else if (cur_reg.aw_addr == DATA_ADDR) begin
        cur_next.data_word = cur_reg.w_data[15:0];
      end else if (cur_reg.aw_addr != CONFIG_ADDR) begin
        cur_next.rsp.bresp = 2'b10;
      end
    end

    // page load discarded by an eeprom write
    if (eeprom_write_start) begin
      cur_next.loaded = '0; // see [R12]
      cur_next.buffer = '0;
    end

    case (cur_reg.state)
      ST_IDLE: begin
        if (store_strobe && cur_reg.arm_cnt != 3'd0 && !armed) begin
          cur_next.arm_cnt = 3'd0;
          if (cur_reg.ctrl == PAT_LOAD) begin
            if (!cur_reg.eep_busy) begin
              cur_next.buffer[word_of(cur_reg.pointer)] = cur_reg.data_word; // see [R9]
              cur_next.loaded[word_of(cur_reg.pointer)] = 1'b1;
            end
            cur_next.ctrl = 6'h00;
          end else begin
            cur_next.state = ST_BUSY;
            cur_next.timer = TW'(PROG_TIME); // see [R24]
            cur_next.latch_page = page_of(cur_reg.pointer); // see [R4]
            cur_next.cmd.start = 1'b1;
            cur_next.cmd.page_base = page_of(cur_reg.pointer);
            cur_next.cmd.lock_clear_mask = ~cur_reg.data_word[5:0];
            if (cur_reg.ctrl == PAT_LOCK) begin
              cur_next.op = OP_LOCK; // see [R5] [R20]
              cur_next.cmd.op = OP_LOCK;
            end else begin
              cur_next.op = (cur_reg.ctrl == PAT_ERASE) ? OP_ERASE : OP_WRITE; // see [R7] [R13]
              cur_next.cmd.op = cur_next.op;
              cur_next.busy_flag = 1'b1; // see [R16]
              cur_next.halt = page_of(cur_reg.pointer) >= HALT_SECTION_START; // see [R8] [R14]
            end
          end
        end
      end
      ST_BUSY: begin
        cur_next.cmd.word = cur_reg.buffer[WORD_BITS'(cur_reg.timer)];
        cur_next.timer = cur_reg.timer - TW'(1);
        if (cur_reg.timer == TW'(1)) begin
          cur_next.state = ST_IDLE;
          cur_next.halt = 1'b0;
          cur_next.ctrl = 6'h00; // see [R25]
          if (cur_reg.op == OP_LOCK) begin
            // a zero in the lock byte programs that bit; only reset unprograms one, reloading LOCK_RESET
            cur_next.lock_bits = cur_reg.lock_bits & ~cur_reg.cmd.lock_clear_mask; // see [R19]
          end else if (cur_reg.op == OP_WRITE) begin
            cur_next.loaded = '0; // see [R10]
            cur_next.buffer = '0;
          end
        end
      end
      default: cur_next.state = ST_IDLE;
    endcase

    cur_next.irq = cur_next.irq_en && !cur_next.ctrl[CTL_ENABLE]; // see [R15]

    // read channel
    if (cur_reg.rsp.rvalid && bus_req.rready) begin
      cur_next.rsp.rvalid = 1'b0;
    end
    cur_next.rsp.arready = !cur_next.rsp.rvalid && !bus_req.arvalid;
    if (bus_req.arvalid && cur_reg.rsp.arready) begin
      cur_next.rsp.rvalid = 1'b1;
      cur_next.rsp.rdata = read_mux(cur_reg, bus_req.araddr[7:0]);
      cur_next.rsp.rresp = 2'b00;
      cur_next.rsp.arready = 1'b0;
    end else if (!cur_next.rsp.rvalid) begin
      cur_next.rsp.arready = 1'b1;
    end
    if (wr_fire) begin
      cur_next.rsp.awready = 1'b0;
      cur_next.rsp.wready = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur_reg <= '0;
      cur_reg.lock_bits <= LOCK_RESET;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign bus_rsp = cur_reg.rsp;
  assign reset_vector = cur_reg.vector;
  assign cpu_halt = cur_reg.halt;
  assign section_busy_flag = cur_reg.busy_flag;
  assign ready_irq = cur_reg.irq;
  assign flash_cmd = cur_reg.cmd;

endmodule

`default_nettype wire

// ===== verification/cpu_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// far side: the core fires a store a chosen number of cycles after being asked
module cpu_core_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic issue,
  input wire logic [3:0] store_delay,
  output logic store_strobe
);
  logic [3:0] cnt_reg;
  logic pend_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      pend_reg <= 1'b0;
      store_strobe <= 1'b0;
    end else begin
      store_strobe <= 1'b0;
      if (issue) begin
        cnt_reg <= store_delay;
        pend_reg <= 1'b1;
      end else if (pend_reg && cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end else if (pend_reg) begin
        store_strobe <= 1'b1;
        pend_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/flash_self_programming_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module flash_self_programming_ctrl_properties
  import selfprog_pkg::*;
#(
  parameter int unsigned PROG_TIME = PROG_CYCLES,
  parameter logic [15:0] BOOT_START = 16'h1C00,
  parameter logic [15:0] HALT_SECTION_START = 16'h1C00
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire axil_req_t bus_req,
  input wire axil_rsp_t bus_rsp,
  input wire logic store_strobe,
  input wire logic boot_vector_select_fuse,
  input wire logic eeprom_write_busy,
  input wire logic eeprom_write_start,
  input wire logic [15:0] reset_vector,
  input wire logic cpu_halt,
  input wire logic section_busy_flag,
  input wire logic ready_irq,
  input wire flash_cmd_t flash_cmd
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [1:0] since_reg;
  logic fuse_reg;
  logic [31:0] halt_reg;
  logic flash_op;
  assign flash_op = flash_cmd.start && flash_cmd.op != OP_LOCK;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      since_reg <= 2'h0;
      fuse_reg <= 1'b0;
      halt_reg <= 32'h0;
    end else begin
      since_reg <= (since_reg == 2'h3) ? since_reg : since_reg + 2'h1;
      fuse_reg <= (since_reg == 2'h0) ? boot_vector_select_fuse : fuse_reg;
      halt_reg <= cpu_halt ? halt_reg + 32'h1 : 32'h0;
    end
  end
  // the eeprom busy synchroniser lets a command already armed slip through for a few cycles
  sequence eep_held;
    eeprom_write_busy [*8] ##1 eeprom_write_busy [*4];
  endsequence
  sequence quiet_lock;
    (!cpu_halt && !$rose(section_busy_flag)) [*8];
  endsequence
  vector_sel_a: assert property (since_reg == 2'h3 |->
    reset_vector == (fuse_reg ? APP_RESET_VECTOR : BOOT_START)) else $error("bad vector");
  start_pulse_a: assert property (flash_cmd.start |=> !flash_cmd.start) else $error("long start");
  start_cause_a: assert property (flash_cmd.start |-> $past(store_strobe)) else $error("no store");
  busy_set_a: assert property (flash_op |-> ##[0:1] section_busy_flag) else $error("no busy");
  halt_page_a: assert property (flash_op && flash_cmd.page_base >= HALT_SECTION_START |->
    ##[0:1] cpu_halt) else $error("no halt");
  halt_time_a: assert property ($fell(cpu_halt) |-> halt_reg + 2 >= PROG_TIME &&
    halt_reg <= PROG_TIME + 2) else $error("halt length");
  irq_quiet_a: assert property (flash_op |=> !ready_irq [*8]) else $error("irq in op");
  lock_quiet_a: assert property (flash_cmd.start && flash_cmd.op == OP_LOCK |-> quiet_lock)
    else $error("lock blocked");
  eep_refuse_a: assert property (eep_held |-> !flash_cmd.start) else $error("eep start");
  read_answer_a: assert property (bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid)
    else $error("late read");
endmodule
bind flash_self_programming_ctrl flash_self_programming_ctrl_properties #(.PROG_TIME(PROG_TIME),
  .BOOT_START(BOOT_START), .HALT_SECTION_START(HALT_SECTION_START)) i_props (
  .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_rsp(bus_rsp),
  .store_strobe(store_strobe), .boot_vector_select_fuse(boot_vector_select_fuse),
  .eeprom_write_busy(eeprom_write_busy), .eeprom_write_start(eeprom_write_start),
  .reset_vector(reset_vector), .cpu_halt(cpu_halt), .section_busy_flag(section_busy_flag),
  .ready_irq(ready_irq), .flash_cmd(flash_cmd));
`default_nettype wire

// ===== verification/test_flash_self_programming_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module test_flash_self_programming_ctrl;
  import selfprog_pkg::*;
  localparam logic [15:0] BS = 16'h1C00;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  axil_req_t bus_req = '0;
  axil_rsp_t bus_rsp;
  logic store_strobe, cpu_halt, section_busy_flag, ready_irq;
  logic fuse = 1'b1, eep_busy = 1'b0, eep_start = 1'b0, issue = 1'b0;
  logic [3:0] delay = 4'h0;
  logic [15:0] reset_vector, w, page_seen;
  flash_cmd_t flash_cmd;
  int fails = 0, num_checks = 0, starts = 0, s;
  logic [31:0] rd, seed = 32'hBE1DEF0F;
  logic [1:0] rsp;
  logic [15:0] buf_m [int];
  logic [5:0] lock_m = LOCK_RESET;
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (flash_cmd.start === 1'b1) begin
      starts <= starts + 1;
      page_seen <= flash_cmd.page_base;
    end
  end
  flash_self_programming_ctrl #(.PROG_TIME(20), .BOOT_START(BS)) i_dut (.core_clk(core_clk),
    .rst(rst), .bus_req(bus_req), .bus_rsp(bus_rsp), .store_strobe(store_strobe),
    .boot_vector_select_fuse(fuse), .eeprom_write_busy(eep_busy), .eeprom_write_start(eep_start),
    .reset_vector(reset_vector), .cpu_halt(cpu_halt), .section_busy_flag(section_busy_flag),
    .ready_irq(ready_irq), .flash_cmd(flash_cmd));
  cpu_core_model i_cpu (.core_clk(core_clk), .rst(rst), .issue(issue), .store_delay(delay),
    .store_strobe(store_strobe));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // valid/ready looked at on the falling edge: they only move at rising edges
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, wd, b;
    int n;
    b = 1'b0;
    n = 0;
    // one edge between transfers so bready is never lowered and raised in one step
    @(posedge core_clk);
    bus_req.awaddr <= {24'h0, a};
    bus_req.wdata <= d;
    bus_req.awvalid <= 1'b1;
    bus_req.wvalid <= 1'b1;
    bus_req.bready <= 1'b1;
    while (!b && n < 100) begin
      @(negedge core_clk);
      aw = bus_req.awvalid && bus_rsp.awready === 1'b1;
      wd = bus_req.wvalid && bus_rsp.wready === 1'b1;
      b = bus_rsp.bvalid === 1'b1;
      r = bus_rsp.bresp;
      n++;
      @(posedge core_clk);
      if (aw) bus_req.awvalid <= 1'b0;
      if (wd) bus_req.wvalid <= 1'b0;
      if (b) bus_req.bready <= 1'b0;
    end
    if (!b) fails++;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    logic ar, v;
    int n;
    v = 1'b0;
    n = 0;
    @(posedge core_clk);
    bus_req.araddr <= {24'h0, a};
    bus_req.arvalid <= 1'b1;
    bus_req.rready <= 1'b1;
    while (!v && n < 100) begin
      @(negedge core_clk);
      ar = bus_req.arvalid && bus_rsp.arready === 1'b1;
      v = bus_rsp.rvalid === 1'b1;
      d = bus_rsp.rdata;
      n++;
      @(posedge core_clk);
      if (ar) bus_req.arvalid <= 1'b0;
      if (v) bus_req.rready <= 1'b0;
    end
    if (!v) fails++;
  endtask
  // eeprom idle before every control write unless a scenario wants refusal
  task automatic spm(input logic [15:0] p, input logic [15:0] d, input logic [7:0] c,
    input logic [3:0] dl);
    axw(POINTER_ADDR, {16'h0, p}, rsp);
    axw(DATA_ADDR, {16'h0, d}, rsp);
    axw(CTRL_ADDR, {24'h0, c}, rsp);
    delay <= dl;
    issue <= 1'b1;
    @(posedge core_clk);
    issue <= 1'b0;
    repeat (12) @(posedge core_clk);
  endtask
  task automatic bufrd(input logic [15:0] p);
    axw(POINTER_ADDR, {16'h0, p}, rsp);
    axr(BUFREAD_ADDR, rd);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[CTL_ENABLE] !== 1'b0 && n < 60) begin
      axr(CTRL_ADDR, rd);
      n++;
    end
    if (n == 60) fails++;
  endtask
  initial begin
    #200_000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(32'(reset_vector), 32'(APP_RESET_VECTOR));
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      buf_m[i] = seed[15:0];
      spm(16'h0300 | 16'(i * 2), seed[15:0], 8'(PAT_LOAD), 4'h0);
    end
    for (int i = 0; i < 4; i++) begin
      bufrd(16'(i * 2));
      chk(32'(rd[7:0]), 32'(buf_m[i][7:0]));
      bufrd(16'(i * 2 + 1));
      chk(32'(rd[7:0]), 32'(buf_m[i][15:8]));
    end
    eep_start <= 1'b1;
    @(posedge core_clk);
    eep_start <= 1'b0;
    bufrd(16'h0002);
    chk(32'(rd[7:0]), 32'h0);
    $display("test load done");
    axw(CTRL_ADDR, 32'h80, rsp);
    repeat (3) @(posedge core_clk);
    chk(32'(ready_irq), 32'h1);
    spm(16'h0140, xs(seed), 8'h80 | 8'(PAT_ERASE), 4'h0);
    chk(32'(section_busy_flag), 32'h1);
    chk(32'(page_seen), 32'h0100);
    chk(32'(cpu_halt), 32'h0);
    chk(32'(ready_irq), 32'h0);
    axr(CTRL_ADDR, rd);
    chk(32'(rd[CTL_ENABLE]), 32'h1);
    wait_done();
    chk(32'(ready_irq), 32'h1);
    spm(16'h0000, 16'h1234, 8'(PAT_LOAD), 4'h0);
    spm(16'h0000, 16'h0000, 8'(PAT_REENABLE), 4'h0);
    chk(32'(section_busy_flag), 32'h0);
    bufrd(16'h0000);
    chk(32'(rd[7:0]), 32'h0);
    $display("test erase done");
    spm(16'h0000, 16'h5AA5, 8'(PAT_LOAD), 4'h0);
    spm(16'h1F00, 16'hFFFF, 8'(PAT_WRITE), 4'h0);
    chk(32'(cpu_halt), 32'h1);
    axw(POINTER_ADDR, 32'h0, rsp);
    chk(32'(cpu_halt), 32'h1);
    wait_done();
    chk(32'(cpu_halt), 32'h0);
    bufrd(16'h0000);
    chk(32'(rd[7:0]), 32'h0);
    $display("test write done");
    spm(16'h0000, 16'h0000, 8'(PAT_REENABLE), 4'h0);
    seed = xs(seed);
    lock_m = lock_m & seed[5:0];
    spm(seed[31:16], {10'h3, seed[5:0]}, 8'(PAT_LOCK), 4'h0);
    chk(32'(cpu_halt), 32'h0);
    chk(32'(section_busy_flag), 32'h0);
    wait_done();
    axr(LOCK_ADDR, rd);
    chk(32'(rd[5:0]), 32'(lock_m));
    s = starts;
    spm(16'h0140, 16'h0, 8'(PAT_ERASE), 4'h8);
    chk(32'(starts), 32'(s));
    axr(CTRL_ADDR, rd);
    chk(32'(rd[CTL_ENABLE]), 32'h0);
    eep_busy <= 1'b1;
    repeat (6) @(posedge core_clk);
    spm(16'h0140, 16'h0, 8'(PAT_ERASE), 4'h0);
    chk(32'(starts), 32'(s));
    axr(LOCK_ADDR, rd);
    chk(rd, 32'h0);
    eep_busy <= 1'b0;
    axw(8'h40, 32'h1, rsp);
    chk(32'(rsp), 32'h2);
    axr(8'h40, rd);
    chk(rd, 32'h0);
    $display("test lock and refusal done");
    fuse <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(32'(reset_vector), 32'(BS));
    $display("test boot vector done");
    wrap_up();
  end
endmodule
`default_nettype wire
